// file: asm_defines.svh
/*
  Offsets, bit positions, command codes and reset values of the
  assembled move handshake and the command mode input data.
  Assumes it is included by bare name wherever these are needed.
*/
`ifndef ASM_DEFINES_SVH
`define ASM_DEFINES_SVH

// Input data word offsets.
`define OFS_STATUS0 4'h0
`define OFS_STATUS1 4'h1
`define OFS_MOTOR_UP 4'h2
`define OFS_MOTOR_LO 4'h3
`define OFS_ENC_UP 4'h4
`define OFS_ENC_LO 4'h5
`define OFS_CAP_UP 4'h6
`define OFS_CAP_LO 4'h7
`define OFS_CURRENT 4'h8
`define OFS_JERK 4'h9

// Status word 0 bit positions.
`define SW0_MODE 15
`define SW0_OK 14
`define SW0_CFG_ERR 13
`define SW0_CMD_ERR 12
`define SW0_IN_ERR 11
`define SW0_POS_INV 10
`define SW0_WAIT_SEG 9
`define SW0_IN_ASM 8
`define SW0_MOVE_DONE 7
`define SW0_DECEL 6
`define SW0_ACCEL 5

// Command word 0 values and bits, and the word 1 dwell bit.
`define CMD_FIRST_BLOCK 16'h0800
`define CMD_SEGMENT 16'h1800
`define CMD_RUN_ASM 16'h2000
`define CMD_RESET_ERR 16'h0400
`define CMD_PRESET_POS 16'h0200
`define CMD_NONE 16'h0000
`define CW0_SEG_BIT 12
`define CW1_DWELL_BIT 9

// Segment limits, reset values and the decimal divisor.
`define SEG_MAX 5'h10
`define SEG_ZERO 5'h00
`define CFG_ERR_RESET 1'b1
`define POS_INV_RESET 1'b1
`define DIV_DECIMAL 32'sd1000

`endif

// file: asm_pkg.sv
/*
  Types shared by the assembled move handshake and its helpers.
  Assumes asm_defines.svh holds the numeric constants.
*/
package asm_pkg;

  typedef enum logic [1:0] {
    ASM_IDLE,
    ASM_WAIT_SEG,
    ASM_SEG_HELD
  } asm_state_t;

  typedef struct packed {
    logic [31:0] rel_pos;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] jerk;
  } seg_t;

  typedef logic [3:0] seg_idx_t;

endpackage

// file: seg_store.sv
/*
  Sixteen entry store of assembled move segments with registered read.
  Assumes one write per cycle at most and a synchronous reset.
*/
`timescale 1ns/1ps
module seg_store
  import asm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Write side.
  input wire logic we,
  input wire asm_pkg::seg_idx_t waddr,
  input wire asm_pkg::seg_t wdata,
  // Read side.
  input wire asm_pkg::seg_idx_t raddr,
  output asm_pkg::seg_t rdata
);
  import asm_pkg::*;

  typedef struct packed {
    seg_t [15:0] mem;
    seg_t rdata;
  } store_t;

  store_t s_r;
  store_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (we) begin
      s_nxt.mem[waddr] = wdata;
    end
    s_nxt.rdata = s_r.mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;

endmodule // seg_store

// file: pos_format.sv
/*
  Turns one signed position into its two input data words.
  Assumes format bits are static between configuration writes.
*/
`timescale 1ns/1ps
`include "asm_defines.svh"
module pos_format
  import asm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Format selection.
  input wire logic binary_fmt,
  input wire logic binary_endian,
  // Position in and words out.
  input wire logic signed [31:0] pos,
  output logic [15:0] word_up,
  output logic [15:0] word_lo
);
  import asm_pkg::*;

  typedef struct packed {
    logic [15:0] up;
    logic [15:0] lo;
  } fmt_t;

  fmt_t s_r;
  fmt_t s_nxt;
  logic signed [31:0] quot;
  logic signed [31:0] rem;
  logic signed [31:0] rem_abs;

  always_comb begin
    quot = pos / `DIV_DECIMAL;
    rem = pos % `DIV_DECIMAL;
    rem_abs = (rem < 0) ? -rem : rem;
    s_nxt = s_r;
    if (!binary_fmt) begin
      // Outside the split range the upper word wraps and reads as garbage.
      s_nxt.up = quot[15:0];
      s_nxt.lo = rem_abs[15:0];
    end else if (!binary_endian) begin
      s_nxt.up = pos[31:16];
      s_nxt.lo = pos[15:0];
    end else begin
      s_nxt.up = pos[15:0];
      s_nxt.lo = pos[31:16];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign word_up = s_r.up;
  assign word_lo = s_r.lo;

endmodule // pos_format

// file: asm_status.sv
/*
  Command mode network data logic: assembled move programming handshake,
  command decode for the commands it owns, status word 0 and the ten
  word input data read port.
  Assumes command words are levels sampled every clock and that the
  motion engine reports its events as one-cycle pulses.
*/
// How it works
// - First block sets in-mode and awaiting-segment flags.
// - Bit 12 high captures segment, clears awaiting.
// - Bit 12 low sets awaiting flag again.
// - At most sixteen segments per profile.
// - Blend or dwell chosen only at start.
// - Ten input words in fixed order.
// - Positions split decimal or 32-bit binary.
// - Split decimal overflow gives indeterminate words.
// - Bit 15 mode, bit 14 healthy.
// - Bit 13 config error or stall enable.
// - Bit 12 command error, cleared by reset.
// - Bit 11 input error events, reset clears.
// - Bit 10 position invalid blocks absolute moves.
// - Bit 7 move complete set and clear.
// - Jog/registration range error sets complete too.
// - Bits 6 and 5 decelerating and accelerating.
// - Run code starts move; dwell bit, time.
// - Reset errors keeps position and config flags.
`timescale 1ns/1ps
`include "asm_defines.svh"
module asm_status
  import asm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Command words from the network host.
  input wire logic [15:0] cmd_w0,
  input wire logic [15:0] cmd_w1,
  input wire logic [15:0] cmd_w2,
  input wire logic [15:0] cmd_w3,
  input wire logic [15:0] cmd_w4,
  input wire logic [15:0] cmd_w5,
  input wire logic [15:0] cmd_w6,
  input wire logic [15:0] cmd_w7,
  input wire logic [15:0] cmd_w9,
  // Input data read port.
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data,
  // Configuration state.
  input wire logic mode_config,
  input wire logic fault_present,
  input wire logic cfg_valid_write,
  input wire logic cfg_invalid_write,
  input wire logic stall_enabled,
  input wire logic binary_fmt,
  input wire logic binary_endian,
  // Motion events and state.
  input wire logic invalid_cmd,
  input wire logic jog_param_error,
  input wire logic estop_event,
  input wire logic limit_in_move,
  input wire logic jog_into_limit,
  input wire logic home_opposite_limit,
  input wire logic unreferenced,
  input wire logic net_reconnect,
  input wire logic stop_event,
  input wire logic limit_reached,
  input wire logic stall_event,
  input wire logic home_done,
  input wire logic move_done_ok,
  input wire logic decelerating,
  input wire logic accelerating,
  input wire logic [4:0] status_low,
  // Data for the other input words.
  input wire logic [15:0] status_word_one,
  input wire logic signed [31:0] motor_pos,
  input wire logic signed [31:0] encoder_pos,
  input wire logic signed [31:0] captured_pos,
  input wire logic [15:0] current_tenths,
  input wire logic [15:0] jerk_value,
  // Toward the motion engine.
  input wire asm_pkg::seg_idx_t seg_rd_idx,
  output asm_pkg::seg_t seg_rd,
  output logic [4:0] seg_total,
  output logic run_start,
  output logic run_dwell,
  output logic [15:0] dwell_ms,
  output logic move_start,
  output logic preset_start,
  output logic reset_errors,
  output logic abs_refused
);
  import asm_pkg::*;

  typedef struct packed {
    asm_state_t state;
    logic [15:0] prev_w0;
    logic [4:0] seg_count;
    logic cfg_error;
    logic cmd_error;
    logic input_error;
    logic pos_invalid;
    logic move_complete;
    logic [15:0] sw0;
    logic [15:0] rd_data;
    logic run_start;
    logic run_dwell;
    logic [15:0] dwell_ms;
    logic move_start;
    logic preset_start;
    logic reset_errors;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    state: ASM_IDLE,
    prev_w0: `CMD_NONE,
    seg_count: `SEG_ZERO,
    cfg_error: `CFG_ERR_RESET,
    cmd_error: 1'b0,
    input_error: 1'b0,
    pos_invalid: `POS_INV_RESET,
    move_complete: 1'b0,
    sw0: 16'h0000,
    rd_data: 16'h0000,
    run_start: 1'b0,
    run_dwell: 1'b0,
    dwell_ms: 16'h0000,
    move_start: 1'b0,
    preset_start: 1'b0,
    reset_errors: 1'b0
  };

  ctl_t s_r;
  ctl_t s_nxt;

  logic new_cmd;
  logic leave_asm;
  logic take_cmd;
  logic seg_we;
  seg_t seg_wdata;
  logic [15:0] motor_up;
  logic [15:0] motor_lo;
  logic [15:0] enc_up;
  logic [15:0] enc_lo;
  logic [15:0] cap_up;
  logic [15:0] cap_lo;
  logic set_cmd_err;
  logic clr_cmd_err;
  logic set_in_err;
  logic clr_in_err;
  logic set_pos_inv;
  logic clr_pos_inv;
  logic set_done;
  logic clr_done;

  // Segment words straight from the command block; word 8 is not kept.
  assign seg_wdata = '{
    rel_pos: {cmd_w2, cmd_w3},
    speed: {cmd_w4, cmd_w5},
    accel: cmd_w6,
    decel: cmd_w7,
    jerk: cmd_w9
  };

  seg_store u_seg_store (
    .clk(clk),
    .resetn(resetn),
    .we(seg_we),
    .waddr(s_r.seg_count[3:0]),
    .wdata(seg_wdata),
    .raddr(seg_rd_idx),
    .rdata(seg_rd)
  );

  pos_format u_fmt_motor (
    .clk(clk),
    .resetn(resetn),
    .binary_fmt(binary_fmt),
    .binary_endian(binary_endian),
    .pos(motor_pos),
    .word_up(motor_up),
    .word_lo(motor_lo)
  );

  pos_format u_fmt_enc (
    .clk(clk),
    .resetn(resetn),
    .binary_fmt(binary_fmt),
    .binary_endian(binary_endian),
    .pos(encoder_pos),
    .word_up(enc_up),
    .word_lo(enc_lo)
  );

  pos_format u_fmt_cap (
    .clk(clk),
    .resetn(resetn),
    .binary_fmt(binary_fmt),
    .binary_endian(binary_endian),
    .pos(captured_pos),
    .word_up(cap_up),
    .word_lo(cap_lo)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.run_start = 1'b0;
    s_nxt.move_start = 1'b0;
    s_nxt.preset_start = 1'b0;
    s_nxt.reset_errors = 1'b0;
    seg_we = 1'b0;
    set_cmd_err = invalid_cmd | jog_param_error;
    clr_cmd_err = 1'b0;
    set_in_err = estop_event | limit_in_move | jog_into_limit | home_opposite_limit;
    clr_in_err = 1'b0;
    set_pos_inv = cfg_valid_write | cfg_invalid_write | unreferenced | net_reconnect
                  | stop_event | limit_reached | stall_event;
    clr_pos_inv = home_done;
    set_done = move_done_ok | jog_param_error;
    clr_done = 1'b0;
    s_nxt.prev_w0 = cmd_w0;
    new_cmd = (cmd_w0 != s_r.prev_w0) && (cmd_w0 != `CMD_NONE);
    leave_asm = (s_r.state == ASM_WAIT_SEG) && new_cmd && !cmd_w0[`CW0_SEG_BIT]
                && (cmd_w0 != `CMD_FIRST_BLOCK);
    take_cmd = new_cmd && ((s_r.state == ASM_IDLE) || leave_asm);

    unique case (s_r.state)
      ASM_IDLE: begin
      end
      ASM_WAIT_SEG: begin
        if (cmd_w0[`CW0_SEG_BIT]) begin
          if (s_r.seg_count < `SEG_MAX) begin
            seg_we = 1'b1;
            s_nxt.seg_count = s_r.seg_count + 5'h01;
          end else begin
            set_cmd_err = 1'b1;
          end
          s_nxt.state = ASM_SEG_HELD;
        end else if (leave_asm) begin
          s_nxt.state = ASM_IDLE;
        end
      end
      ASM_SEG_HELD: begin
        if (!cmd_w0[`CW0_SEG_BIT]) begin
          s_nxt.state = ASM_WAIT_SEG;
        end
      end
    endcase

    if (take_cmd) begin
      unique case (cmd_w0)
        `CMD_FIRST_BLOCK: begin
          s_nxt.state = ASM_WAIT_SEG;
          s_nxt.seg_count = `SEG_ZERO;
        end
        `CMD_SEGMENT: begin
          set_cmd_err = 1'b1;
        end
        `CMD_RUN_ASM: begin
          if (s_r.seg_count == `SEG_ZERO) begin
            set_cmd_err = 1'b1;
          end else begin
            s_nxt.run_start = 1'b1;
            s_nxt.run_dwell = cmd_w1[`CW1_DWELL_BIT];
            s_nxt.dwell_ms = cmd_w9;
            clr_done = 1'b1;
          end
        end
        `CMD_RESET_ERR: begin
          s_nxt.reset_errors = 1'b1;
          clr_cmd_err = 1'b1;
          clr_in_err = 1'b1;
          clr_done = 1'b1;
        end
        `CMD_PRESET_POS: begin
          s_nxt.preset_start = 1'b1;
          clr_pos_inv = 1'b1;
          clr_done = 1'b1;
        end
        default: begin
          s_nxt.move_start = 1'b1;
          clr_done = 1'b1;
        end
      endcase
    end

    // Each event wins over a clear arriving in the same cycle.
    s_nxt.cmd_error = (s_r.cmd_error & ~clr_cmd_err) | set_cmd_err;
    s_nxt.input_error = (s_r.input_error & ~clr_in_err) | set_in_err;
    s_nxt.pos_invalid = (s_r.pos_invalid & ~clr_pos_inv) | set_pos_inv;
    s_nxt.move_complete = (s_r.move_complete & ~clr_done) | set_done;
    if (cfg_invalid_write) begin
      s_nxt.cfg_error = 1'b1;
    end else if (cfg_valid_write) begin
      s_nxt.cfg_error = 1'b0;
    end

    s_nxt.sw0 = {
      mode_config,
      ~fault_present,
      mode_config ? stall_enabled : s_nxt.cfg_error,
      s_nxt.cmd_error,
      s_nxt.input_error,
      s_nxt.pos_invalid,
      s_nxt.state == ASM_WAIT_SEG,
      s_nxt.state != ASM_IDLE,
      s_nxt.move_complete,
      decelerating,
      accelerating,
      status_low
    };

    unique case (rd_addr)
      `OFS_STATUS0: s_nxt.rd_data = s_r.sw0;
      `OFS_STATUS1: s_nxt.rd_data = status_word_one;
      `OFS_MOTOR_UP: s_nxt.rd_data = motor_up;
      `OFS_MOTOR_LO: s_nxt.rd_data = motor_lo;
      `OFS_ENC_UP: s_nxt.rd_data = enc_up;
      `OFS_ENC_LO: s_nxt.rd_data = enc_lo;
      `OFS_CAP_UP: s_nxt.rd_data = cap_up;
      `OFS_CAP_LO: s_nxt.rd_data = cap_lo;
      `OFS_CURRENT: s_nxt.rd_data = current_tenths;
      `OFS_JERK: s_nxt.rd_data = jerk_value;
      default: s_nxt.rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= CTL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd_data;
  assign seg_total = s_r.seg_count;
  assign run_start = s_r.run_start;
  assign run_dwell = s_r.run_dwell;
  assign dwell_ms = s_r.dwell_ms;
  assign move_start = s_r.move_start;
  assign preset_start = s_r.preset_start;
  assign reset_errors = s_r.reset_errors;
  // Absolute moves are turned away while the position is not trusted.
  assign abs_refused = s_r.pos_invalid;

endmodule // asm_status

// file: asm_status_chk.sv
/* Port checker of the assembled move handshake and status word 0.
   Assumes read index 0 selects status word 0, answered one edge late. */
`timescale 1ns/1ps
module asm_status_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Host side.
  input wire logic [15:0] cmd_w0,
  input wire logic [3:0] rd_addr,
  input wire logic [15:0] rd_data,
  // Motion engine side.
  input wire logic move_done_ok,
  input wire logic decelerating,
  input wire logic accelerating,
  input wire logic [4:0] seg_total,
  input wire logic run_start,
  input wire logic reset_errors
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // A fresh segment code while status word 0 already shows both flags.
  sequence seg_req;
    (rd_addr == 4'h0 && $stable(cmd_w0)) ##1
    ($changed(cmd_w0) && cmd_w0 == 16'h1800 && rd_data[9:8] == 2'b11);
  endsequence
  AST_FIRST_FLAGS: assert property (
    ($changed(cmd_w0) && cmd_w0 == 16'h0800) ##1 rd_addr == 4'h0 |=> rd_data[9:8] == 2'b11
  ) else $error("programming flags not raised");
  AST_SEG_COUNT: assert property (
    seg_req ##0 seg_total < 5'h10 |=> seg_total == $past(seg_total) + 5'h01
  ) else $error("segment not counted");
  AST_SEG_ACK: assert property (
    seg_req ##1 rd_addr == 4'h0 |=> !rd_data[9]
  ) else $error("awaiting flag not cleared");
  AST_SEG_LIMIT: assert property (
    $changed(cmd_w0) && cmd_w0 == 16'h1800 && seg_total == 5'h10 |=> seg_total == 5'h10 [*2]
  ) else $error("segment beyond sixteen stored");
  AST_RUN_REFUSED: assert property (
    $changed(cmd_w0) && cmd_w0 == 16'h2000 && seg_total == 5'h00 |=> !run_start [*3]
  ) else $error("empty profile started");
  AST_RESET_PULSE: assert property (
    $changed(cmd_w0) && cmd_w0 == 16'h0400 |=> reset_errors ##1 !reset_errors
  ) else $error("reset errors pulse wrong");
  AST_MOVE_DONE: assert property (
    move_done_ok ##1 rd_addr == 4'h0 |=> rd_data[7]
  ) else $error("move complete not set");
  AST_RAMP_BITS: assert property (
    resetn ##1 rd_addr == 4'h0 |=> rd_data[6:5] == $past({decelerating, accelerating}, 2)
  ) else $error("ramp bits wrong");
endmodule // asm_status_chk
bind asm_status asm_status_chk asm_status_chk_inst (.clk, .resetn, .cmd_w0, .rd_addr, .rd_data,
  .move_done_ok, .decelerating, .accelerating, .seg_total, .run_start, .reset_errors);

// file: host_model.sv
/* Network host model: writes command words and polls the input data.
   Assumes the device samples command words on the rising clock edge. */
`timescale 1ns/1ps
`include "asm_defines.svh"
module host_model (
  // Clock and input data.
  input wire logic clk,
  input wire logic [15:0] rd_data,
  // Command words and read index.
  output logic [15:0] cmd_w0,
  output logic [15:0] cmd_w1,
  output logic [15:0] cmd_w2,
  output logic [15:0] cmd_w3,
  output logic [15:0] cmd_w4,
  output logic [15:0] cmd_w5,
  output logic [15:0] cmd_w6,
  output logic [15:0] cmd_w7,
  output logic [15:0] cmd_w9,
  output logic [3:0] rd_addr
);
  initial begin
    {cmd_w0, cmd_w1, cmd_w2, cmd_w3, cmd_w4, cmd_w5, cmd_w6, cmd_w7, cmd_w9} = '0;
    rd_addr = 4'h0;
  end
  task automatic wr(input logic [15:0] w0);
    @(posedge clk);
    #2 cmd_w0 = w0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    #2 rd_addr = a;
    @(posedge clk);
    #2 d = rd_data;
  endtask
  // Gives up after 32 reads; the caller judges the last word.
  task automatic poll(input logic [15:0] m, input logic [15:0] v, output logic [15:0] s);
    for (int i = 0; i < 32; i++) begin
      rd(`OFS_STATUS0, s);
      if ((s & m) === v) break;
    end
  endtask
  task automatic load_profile(input int n, output logic [15:0] s);
    wr(`CMD_FIRST_BLOCK);
    poll(16'h0300, 16'h0300, s);
    for (int i = 0; i < n; i++) begin
      {cmd_w2, cmd_w3} = 32'(32'hff80_0000 + i);
      {cmd_w4, cmd_w5} = 32'h002d_c6bf;
      cmd_w6 = 16'(i + 1);
      cmd_w7 = 16'h1388;
      // Word eight has no port, so it is never driven or stored.
      cmd_w9 = 16'(i);
      wr(`CMD_SEGMENT);
      poll(16'h0200, 16'h0000, s);
      wr(`CMD_FIRST_BLOCK);
      poll(16'h0200, 16'h0200, s);
    end
  endtask
  task automatic run(input logic dwell, input logic [15:0] ms);
    cmd_w1 = {6'h00, dwell, 9'h000};
    cmd_w9 = ms;
    wr(`CMD_RUN_ASM);
    wr(`CMD_NONE);
  endtask
endmodule // host_model

// file: test_asm_status.sv
/* Self-checking bench of the assembled move handshake and the input data.
   Assumes host_model drives the command words and the read index. */
`timescale 1ns/1ps
`include "asm_defines.svh"
module test_asm_status;
  import asm_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] cmd_w0, cmd_w1, cmd_w2, cmd_w3, cmd_w4, cmd_w5, cmd_w6, cmd_w7, cmd_w9;
  logic [15:0] rd_data, dwell_ms, s, w, e;
  logic [3:0] rd_addr;
  seg_idx_t seg_rd_idx = 4'h0;
  seg_t seg_rd;
  logic [4:0] seg_total;
  logic [4:0] status_low = 5'h15;
  logic run_start, run_dwell, move_start, preset_start, reset_errors, abs_refused;
  // Event pulses, indexed as wired at the instance below.
  logic [14:0] ev = 15'h0000;
  logic mode_config = 1'b0, fault_present = 1'b0, stall_enabled = 1'b0;
  logic binary_fmt = 1'b0, binary_endian = 1'b0, decelerating = 1'b0, accelerating = 1'b0;
  logic [15:0] status_word_one = 16'ha5c3, current_tenths = 16'h0019, jerk_value = 16'h1388;
  // Positions -1234567, 32767999 and -32768000, the last two at the decimal range ends.
  logic signed [31:0] motor_pos = 32'hffed_2979, encoder_pos = 32'h01f3_ffff;
  logic signed [31:0] captured_pos = 32'hfe0c_0000;
  // Words 2 to 7 in split decimal, then binary in both word orders.
  logic [95:0] pos_exp [3] = '{96'hfb2e_0237_7fff_03e7_8000_0000,
    96'hffed_2979_01f3_ffff_fe0c_0000, 96'h2979_ffed_ffff_01f3_0000_fe0c};
  logic [15:0] fixed [11] = '{16'h6415, 16'ha5c3, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0019, 16'h1388, 16'h0000};
  int failures = 0;
  int check_count = 0;
  // Pulse outputs are counted on the falling edge, where they have settled.
  logic [7:0] run_cnt = 8'h00, move_cnt = 8'h00, preset_cnt = 8'h00, clr_cnt = 8'h00;
  always #25 clk = ~clk;
  always @(negedge clk) begin
    if (resetn) begin
      run_cnt <= run_cnt + {7'h00, run_start};
      move_cnt <= move_cnt + {7'h00, move_start};
      preset_cnt <= preset_cnt + {7'h00, preset_start};
      clr_cnt <= clr_cnt + {7'h00, reset_errors};
    end
  end
  asm_status asm_status_inst (.clk, .resetn, .cmd_w0, .cmd_w1, .cmd_w2, .cmd_w3, .cmd_w4,
    .cmd_w5, .cmd_w6, .cmd_w7, .cmd_w9, .rd_addr, .rd_data, .mode_config, .fault_present,
    .cfg_valid_write(ev[13]), .cfg_invalid_write(ev[14]), .stall_enabled, .binary_fmt,
    .binary_endian, .invalid_cmd(ev[0]), .jog_param_error(ev[1]), .estop_event(ev[2]),
    .limit_in_move(ev[3]), .jog_into_limit(ev[4]), .home_opposite_limit(ev[5]),
    .unreferenced(ev[6]), .net_reconnect(ev[7]), .stop_event(ev[8]), .limit_reached(ev[9]),
    .stall_event(ev[10]), .home_done(ev[11]), .move_done_ok(ev[12]), .decelerating,
    .accelerating, .status_low, .status_word_one, .motor_pos, .encoder_pos, .captured_pos,
    .current_tenths, .jerk_value, .seg_rd_idx, .seg_rd, .seg_total, .run_start, .run_dwell,
    .dwell_ms, .move_start, .preset_start, .reset_errors, .abs_refused);
  host_model host_model_inst (.clk, .rd_data, .cmd_w0, .cmd_w1, .cmd_w2, .cmd_w3, .cmd_w4,
    .cmd_w5, .cmd_w6, .cmd_w7, .cmd_w9, .rd_addr);
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    #2 ev[i] = 1'b1;
    @(posedge clk);
    #2 ev[i] = 1'b0;
  endtask
  task automatic cmd(input logic [15:0] c);
    host_model_inst.wr(c);
    host_model_inst.wr(`CMD_NONE);
  endtask
  task automatic sw0();
    host_model_inst.rd(`OFS_STATUS0, s);
  endtask
  task print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #2 resetn = 1'b1;
    for (int f = 0; f < 3; f++) begin
      binary_fmt = (f != 0);
      binary_endian = (f == 2);
      for (int a = 0; a < 11; a++) begin
        host_model_inst.rd(4'(a), w);
        e = (a > 1 && a < 8) ? pos_exp[f][(7 - a) * 16 +: 16] : fixed[a];
        check(w, e);
      end
    end
    host_model_inst.load_profile(2, s);
    check(s[9:8], 2'b11);
    check(seg_total, 5'h02);
    for (int i = 0; i < 2; i++) begin
      seg_rd_idx = 4'(i);
      repeat (2) @(posedge clk);
      #2 e = 16'(i);
      check(seg_rd, {32'(32'hff80_0000 + i), 32'h002d_c6bf, e + 16'h0001, 16'h1388, e});
    end
    host_model_inst.run(1'b1, 16'h1234);
    sw0();
    check(s[9:8], 2'b00);
    check({run_dwell, dwell_ms}, 17'h11234);
    host_model_inst.load_profile(17, s);
    check(seg_total, 5'h10);
    check(s[12], 1'b1);
    host_model_inst.run(1'b0, 16'h0000);
    check(run_dwell, 1'b0);
    cmd(`CMD_RESET_ERR);
    sw0();
    check({s[13:12], s[10]}, 3'b101);
    host_model_inst.load_profile(0, s);
    host_model_inst.run(1'b0, 16'h0000);
    sw0();
    check(s[12], 1'b1);
    for (int i = 2; i < 6; i++) begin
      cmd(`CMD_RESET_ERR);
      pulse(i);
      sw0();
      check({s[12:11], s[7]}, 3'b010);
    end
    for (int i = 6; i < 11; i++) begin
      pulse(11);
      sw0();
      check({s[10], abs_refused}, 2'b00);
      pulse(i);
      sw0();
      check({s[10], abs_refused}, 2'b11);
    end
    pulse(12);
    cmd(`CMD_PRESET_POS);
    sw0();
    check({s[10], s[7]}, 2'b00);
    pulse(12);
    sw0();
    check(s[7], 1'b1);
    cmd(16'h0100);
    sw0();
    check(s[7], 1'b0);
    pulse(1);
    sw0();
    check({s[12], s[7]}, 2'b11);
    cmd(`CMD_RESET_ERR);
    pulse(0);
    sw0();
    check({s[12], s[7]}, 2'b10);
    pulse(13);
    sw0();
    check({s[13], s[10]}, 2'b01);
    pulse(14);
    sw0();
    check(s[13], 1'b1);
    mode_config = 1'b1;
    fault_present = 1'b1;
    decelerating = 1'b1;
    sw0();
    check({s[15:13], s[6:5]}, 5'b10010);
    stall_enabled = 1'b1;
    fault_present = 1'b0;
    decelerating = 1'b0;
    accelerating = 1'b1;
    sw0();
    check({s[15:13], s[6:5]}, 5'b11101);
    cmd(`CMD_RESET_ERR);
    sw0();
    check(s[12], 1'b0);
    cmd(`CMD_SEGMENT);
    sw0();
    check({s[12], s[9:8]}, 3'b100);
    check({run_cnt, move_cnt, preset_cnt, clr_cnt}, 32'h0201_0107);
    print_verdict();
  end
  initial begin
    #1000000;
    failures++;
    print_verdict();
  end
endmodule // test_asm_status
